// file: rxd_dma_top.sv
// receive fifo chain, dma pipeline and scatter-gather receive dma with avalon register slave
// Summary of operation
// [RULE_01] status bit 31 shows an enabled channel interrupt condition is pending
// [RULE_02] status bits 30-16 give words held in all stages plus pipeline
// [RULE_03] three 4K x 32 stages, words move downstream whenever room exists
// [RULE_04] stage 0 and 1 moves burst away from level boundaries, single words near them; stage 2 moves single words only
// [RULE_05] each stage holds 4095 words; 4-deep pipeline feeds the dma path
// [RULE_06] stage flags come from that stage's own contents only
// [RULE_07] empty flags bits 0, 4, 7 set when the stage holds no word
// [RULE_08] almost-empty bits 1, 8 set when count at or below low level
// [RULE_09] almost-full bits 2, 5, 9 set when count at or above high level
// [RULE_10] full flags bits 3, 6, 10 set when the stage has no free location
// [RULE_11] bit 11 latches loader write into full stage 0; write one clears
// [RULE_12] bits 13/12 latch dma error on aborts or wrong direction bit
// [RULE_13] bits 15/14 latch dma done when the whole list completes
// [RULE_14] write to read pointer starts dma, fetching three words from that address
// [RULE_15] descriptor is address, byte length, next pointer; walk until end flag
// [RULE_16] pointer bit 0 is end of chain, bit 1 direction, one for receive
// [RULE_17] host keeps descriptors word aligned, physical, lengths multiple of four
// [RULE_18] host leaves end flag clear in the pointer written to the port
// [RULE_19] writing zero to the read pointer port aborts the running dma
// [RULE_20] software leaves the transmit pointer port unused in this variant
// [RULE_21] single word port read returns and removes the next receive word
// [RULE_22] 16-bit level registers, bits 11-0 compared against stage counts
// [RULE_23] software should program high levels sixteen short of the end count
// [RULE_24] channel interrupt reaches the host only with master enable set
// [RULE_25] status count and flags ignore writes; latched bits clear on write one
`timescale 1ns/1ps
module rxd_dma_top
   import rxd_pkg::*;
#(
   parameter int AW         = 12,
   parameter int PIPE_DEPTH = 4
) (
   input  wire logic        REF_CLK,
   input  wire logic        RESET,
   input  wire logic [7:0]  AV_ADDRESS,
   input  wire logic        AV_READ,
   input  wire logic        AV_WRITE,
   input  wire logic [31:0] AV_WRITEDATA,
   output logic [31:0]      AV_READDATA,
   output logic             AV_WAITREQUEST,
   input  wire logic        LOAD_VALID,
   input  wire logic [31:0] LOAD_DATA,
   input  wire logic        MASTER_INT_EN,
   output logic             CHAN_IRQ,
   output logic             MEM_REQ,
   output logic             MEM_WE,
   output logic [31:0]      MEM_ADDR,
   output logic [31:0]      MEM_WDATA,
   input  wire logic        MEM_ACK,
   input  wire logic        MEM_ABORT,
   input  wire logic [31:0] MEM_RDATA
);
   localparam int               CW     = AW + 1;
   localparam logic [AW:0]      USABLE = CW'((2**AW) - 1);
   localparam int               PW     = $clog2(PIPE_DEPTH);

   typedef enum logic [1:0] {RXD_IDLE, RXD_FETCH, RXD_XFER} rxd_state_t;

   function automatic logic f_low(input logic [AW:0] cnt, input logic [LVL_W-1:0] lvl);
      return cnt <= CW'(lvl[LVL_USED-1:0]);
   endfunction

   function automatic logic f_high(input logic [AW:0] cnt, input logic [LVL_W-1:0] lvl);
      return cnt >= CW'(lvl[LVL_USED-1:0]);
   endfunction

   rxd_fifo_if #(.DW(32), .CW(CW)) fq [N_STAGE] ();

   // register state
   logic [31:0]      ctrl_ff;
   logic [LVL_W-1:0] low_ff  [N_STAGE];
   logic [LVL_W-1:0] high_ff [N_STAGE];
   logic             ovr_ff, rd_err_ff, rd_int_ff;
   logic             wait_ff;
   logic [31:0]      rdata_ff;
   logic             irq_ff;

   // chain and pipeline state
   logic [N_STAGE-1:0] pend_ff;
   logic [31:0]        pipe_q [PIPE_DEPTH];
   logic [PW-1:0]      pwp_ff, prp_ff;
   logic [PW:0]        pcnt_ff;

   // dma state
   rxd_state_t  state_ff;
   logic [1:0]  fidx_ff;
   logic [31:0] desc_ff, baddr_ff, next_ff;
   logic [29:0] words_ff;
   logic        req_ff, we_ff;
   logic [31:0] maddr_ff, mwdata_ff;

   // avalon decode; the request completes at the edge where waitrequest is seen low
   wire        acc_take  = (AV_READ || AV_WRITE) && !wait_ff;
   wire        wr_take   = acc_take && AV_WRITE;
   wire        rd_take   = acc_take && AV_READ;
   wire        clr_fifo  = ctrl_ff[CT_FIFO_RST];
   wire        wr_ctrl   = wr_take && AV_ADDRESS == OFS_CTRL;
   wire        wr_stat   = wr_take && AV_ADDRESS == OFS_STATUS;
   wire        wr_rptr   = wr_take && AV_ADDRESS == OFS_RD_PTR;
   wire        swr_take  = rd_take && AV_ADDRESS == OFS_SWR;
   wire [31:0] ptr_wd    = AV_WRITEDATA;

   // stage counts and flags
   wire [AW:0] c0 = fq[0].count;
   wire [AW:0] c1 = fq[1].count;
   wire [AW:0] c2 = fq[2].count;
   wire        e0 = c0 == '0;                                    // see [RULE_07] [RULE_06]
   wire        e1 = c1 == '0;                                    // see [RULE_07]
   wire        e2 = c2 == '0;                                    // see [RULE_07]
   wire        f0 = c0 >= USABLE;                                // see [RULE_10] [RULE_05]
   wire        f1 = c1 >= USABLE;                                // see [RULE_10]
   wire        f2 = c2 >= USABLE;                                // see [RULE_10]
   wire        ae0 = f_low(c0, low_ff[0]);                       // see [RULE_08] [RULE_22]
   wire        ae1 = f_low(c1, low_ff[1]);
   wire        ae2 = f_low(c2, low_ff[2]);                       // see [RULE_08]
   wire        af0 = f_high(c0, high_ff[0]);                     // see [RULE_09] [RULE_22]
   wire        af1 = f_high(c1, high_ff[1]);                     // see [RULE_09]
   wire        af2 = f_high(c2, high_ff[2]);                     // see [RULE_09]

   // words held anywhere in the chain, in-flight moves included
   wire [ST_CNT_W-1:0] total = ST_CNT_W'(c0) + ST_CNT_W'(c1) + ST_CNT_W'(c2)
                             + ST_CNT_W'(pend_ff[0]) + ST_CNT_W'(pend_ff[1])
                             + ST_CNT_W'(pend_ff[2]) + ST_CNT_W'(pcnt_ff);  // see [RULE_02]

   // stage moves: stages 0 and 1 burst back to back, single words spaced out near the levels; stage 2 always moves spaced single words
   wire near0 = ae0 || af1;                                      // see [RULE_04]
   wire near1 = ae1 || af2;                                      // see [RULE_04]
   wire mv0 = !e0 && (c1 + CW'(pend_ff[0]) < USABLE) && (!near0 || !pend_ff[0]); // see [RULE_03]
   wire mv1 = !e1 && (c2 + CW'(pend_ff[1]) < USABLE) && (!near1 || !pend_ff[1]); // see [RULE_03]
   wire mv2 = !e2 && (pcnt_ff + (PW+1)'(pend_ff[2]) < (PW+1)'(PIPE_DEPTH))
            && !pend_ff[2];                                      // see [RULE_05]

   // pipeline drain: dma has priority, the single word port only when no dma data phase
   wire        pipe_ne  = pcnt_ff != '0;
   wire        dma_pop  = state_ff == RXD_XFER && req_ff && we_ff && MEM_ACK;
   wire        swr_pop  = swr_take && pipe_ne && state_ff != RXD_XFER;   // see [RULE_21]
   wire        pop      = dma_pop || swr_pop;
   wire        push     = pend_ff[2];

   wire        ovr_set  = LOAD_VALID && f0;                      // see [RULE_11]
   wire        chan_act = ctrl_ff[CT_CH_IEN] && (ctrl_ff[CT_FORCE] || ovr_ff); // see [RULE_01]

   // dma decode
   wire        fetch_ack = state_ff == RXD_FETCH && req_ff && MEM_ACK;
   wire        last_word = fetch_ack && fidx_ff == 2'd2;
   wire        dir_bad   = last_word && !MEM_RDATA[PTR_DIR];     // see [RULE_16] [RULE_12]
   wire        bus_abort = req_ff && MEM_ABORT;                  // see [RULE_12]
   wire        list_done = state_ff == RXD_XFER && words_ff == '0 && next_ff[PTR_EOC]; // see [RULE_13]
   wire        sw_abort  = wr_rptr && ptr_wd == '0;              // see [RULE_19]
   wire        sw_start  = wr_rptr && ptr_wd != '0 && state_ff == RXD_IDLE; // see [RULE_14]

   wire [31:0] status_w = {chan_act, total, rd_int_ff, 1'b0, rd_err_ff, 1'b0, ovr_ff,
                           f2, af2, ae2, e2, f1, af1, e1, f0, af0, ae0, e0};

   wire [31:0] ctrl_rd  = ctrl_ff | (32'(state_ff == RXD_IDLE) << CT_BO_IDLE);

   // register read mux, unmapped addresses read zero
   wire [31:0] rd_mux =
      AV_ADDRESS == OFS_CTRL   ? ctrl_rd :
      AV_ADDRESS == OFS_STATUS ? status_w :
      AV_ADDRESS == OFS_SWR    ? pipe_q[prp_ff] :
      AV_ADDRESS == OFS_LOW0   ? 32'(low_ff[0]) :
      AV_ADDRESS == OFS_HIGH0  ? 32'(high_ff[0]) :
      AV_ADDRESS == OFS_LOW1   ? 32'(low_ff[1]) :
      AV_ADDRESS == OFS_HIGH1  ? 32'(high_ff[1]) :
      AV_ADDRESS == OFS_LOW2   ? 32'(low_ff[2]) :
      AV_ADDRESS == OFS_HIGH2  ? 32'(high_ff[2]) : 32'h0000_0000;

   // stage memories
   assign fq[0].clr   = clr_fifo;
   assign fq[0].wr    = LOAD_VALID && !f0;
   assign fq[0].wdata = LOAD_DATA;
   assign fq[0].rd    = mv0;
   assign fq[1].clr   = clr_fifo;
   assign fq[1].wr    = pend_ff[0];
   assign fq[1].wdata = fq[0].rdata;
   assign fq[1].rd    = mv1;
   assign fq[2].clr   = clr_fifo;
   assign fq[2].wr    = pend_ff[1];
   assign fq[2].wdata = fq[1].rdata;
   assign fq[2].rd    = mv2;

   for (genvar k = 0; k < N_STAGE; k++) begin : g_stage
      rxd_fifo #(.AW(AW)) u_fifo (
         .REF_CLK (REF_CLK),
         .RESET   (RESET),
         .port    (fq[k])
      );
   end

   // avalon slave: answer one cycle after the request is seen
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         wait_ff  <= 1'b1;
         rdata_ff <= 32'h0000_0000;
      end else begin
         wait_ff  <= !(AV_READ || AV_WRITE) || !wait_ff;
         if (AV_READ && wait_ff) begin
            rdata_ff <= rd_mux;
         end
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         ctrl_ff <= 32'h0000_0000;
      end else if (wr_ctrl) begin
         ctrl_ff <= AV_WRITEDATA & CT_WR_MASK;
      end
   end

   for (genvar k = 0; k < N_STAGE; k++) begin : g_level
      wire wr_low  = wr_take && AV_ADDRESS == OFS_LOW0 + 8'(8 * k);
      wire wr_high = wr_take && AV_ADDRESS == OFS_HIGH0 + 8'(8 * k);
      always_ff @(posedge REF_CLK) begin
         if (RESET) begin
            low_ff[k]  <= LOW_RESET;
            high_ff[k] <= HIGH_RESET;
         end else begin
            if (wr_low) begin
               low_ff[k] <= AV_WRITEDATA[LVL_W-1:0];            // see [RULE_22]
            end
            if (wr_high) begin
               high_ff[k] <= AV_WRITEDATA[LVL_W-1:0];           // see [RULE_22]
            end
         end
      end
   end

   // latched flags: a set in the clearing cycle wins
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         ovr_ff    <= 1'b0;
         rd_err_ff <= 1'b0;
         rd_int_ff <= 1'b0;
         irq_ff    <= 1'b0;
      end else begin
         ovr_ff    <= ovr_set || (ovr_ff && !(wr_stat && AV_WRITEDATA[ST_OVR]));  // see [RULE_11] [RULE_25]
         rd_err_ff <= dir_bad || bus_abort
                   || (rd_err_ff && !(wr_stat && AV_WRITEDATA[ST_RD_ERR]));       // see [RULE_12] [RULE_25]
         rd_int_ff <= list_done || (rd_int_ff && !(wr_stat && AV_WRITEDATA[ST_RD_INT])); // see [RULE_13]
         irq_ff    <= (chan_act && MASTER_INT_EN) || (rd_int_ff && ctrl_ff[CT_RD_IEN]); // see [RULE_24]
      end
   end

   // chain moves and the dma pipeline
   always_ff @(posedge REF_CLK) begin
      if (RESET || clr_fifo) begin
         pend_ff <= '0;
         pwp_ff  <= '0;
         prp_ff  <= '0;
         pcnt_ff <= '0;
      end else begin
         pend_ff <= {mv2, mv1, mv0};
         pwp_ff  <= pwp_ff + PW'(push);
         prp_ff  <= prp_ff + PW'(pop);
         pcnt_ff <= pcnt_ff + (PW+1)'(push) - (PW+1)'(pop);
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (push) begin
         pipe_q[pwp_ff] <= fq[2].rdata;
      end
   end

   // scatter-gather walk
   always_ff @(posedge REF_CLK) begin
      if (RESET || clr_fifo || sw_abort || dir_bad || bus_abort) begin
         state_ff <= RXD_IDLE;                                  // see [RULE_19]
         req_ff   <= 1'b0;
         we_ff    <= 1'b0;
         fidx_ff  <= 2'd0;
         if (RESET) begin
            desc_ff   <= 32'h0000_0000;
            baddr_ff  <= 32'h0000_0000;
            next_ff   <= 32'h0000_0000;
            words_ff  <= '0;
            maddr_ff  <= 32'h0000_0000;
            mwdata_ff <= 32'h0000_0000;
         end
      end else begin
         unique case (state_ff)
            RXD_IDLE: begin
               if (sw_start) begin
                  desc_ff  <= ptr_wd & PTR_ADDR_MASK;           // see [RULE_14]
                  fidx_ff  <= 2'd0;
                  state_ff <= RXD_FETCH;
               end
            end
            RXD_FETCH: begin
               if (!req_ff) begin
                  req_ff   <= 1'b1;
                  we_ff    <= 1'b0;
                  maddr_ff <= desc_ff + 32'(fidx_ff) * WORD_BYTES;  // see [RULE_14]
               end else if (MEM_ACK) begin
                  req_ff  <= 1'b0;
                  fidx_ff <= fidx_ff + 2'd1;
                  unique case (fidx_ff)
                     2'd0: baddr_ff <= MEM_RDATA & PTR_ADDR_MASK;   // see [RULE_15]
                     2'd1: words_ff <= MEM_RDATA[31:2];             // see [RULE_15]
                     default: begin
                        next_ff  <= MEM_RDATA;                      // see [RULE_15]
                        state_ff <= RXD_XFER;
                     end
                  endcase
               end
            end
            RXD_XFER: begin
               if (!req_ff && words_ff == '0) begin
                  fidx_ff  <= 2'd0;
                  desc_ff  <= next_ff & PTR_ADDR_MASK;
                  state_ff <= next_ff[PTR_EOC] ? RXD_IDLE : RXD_FETCH;  // see [RULE_15]
               end else if (!req_ff && pipe_ne) begin
                  req_ff    <= 1'b1;
                  we_ff     <= 1'b1;
                  maddr_ff  <= baddr_ff;
                  mwdata_ff <= pipe_q[prp_ff];
               end else if (req_ff && MEM_ACK) begin
                  req_ff   <= 1'b0;
                  baddr_ff <= baddr_ff + WORD_BYTES;
                  words_ff <= words_ff - 30'd1;
               end
            end
            default: state_ff <= RXD_IDLE;
         endcase
      end
   end

   assign AV_READDATA    = rdata_ff;
   assign AV_WAITREQUEST = wait_ff;
   assign CHAN_IRQ       = irq_ff;
   assign MEM_REQ        = req_ff;
   assign MEM_WE         = we_ff;
   assign MEM_ADDR       = maddr_ff;
   assign MEM_WDATA      = mwdata_ff;

   a_stage_room: assert property (@(posedge REF_CLK) disable iff (RESET)
      fq[1].wr |-> c1 < USABLE) else $error("stage 1 written while full");       // see [RULE_03]
   a_stage_depth: assert property (@(posedge REF_CLK) disable iff (RESET)
      c0 <= USABLE && c1 <= USABLE && c2 <= USABLE) else $error("stage past 4095"); // see [RULE_05]
   a_empty_flag: assert property (@(posedge REF_CLK) disable iff (RESET)
      status_w[ST_E2] == (c2 == '0) && status_w[ST_E0] == (c0 == '0))
      else $error("empty flag wrong");                                            // see [RULE_07]
   a_overrun_latch: assert property (@(posedge REF_CLK) disable iff (RESET)
      (LOAD_VALID && f0) |=> ovr_ff [*2]) else $error("overrun not latched");    // see [RULE_11]
   a_dir_error: assert property (@(posedge REF_CLK) disable iff (RESET)
      dir_bad |=> rd_err_ff && state_ff == RXD_IDLE && !MEM_REQ)
      else $error("bad direction not flagged");                                   // see [RULE_12]
   a_list_done: assert property (@(posedge REF_CLK) disable iff (RESET)
      list_done && !clr_fifo |=> rd_int_ff && state_ff == RXD_IDLE)
      else $error("list end not flagged");                                        // see [RULE_13]
   a_first_fetch: assert property (@(posedge REF_CLK) disable iff (RESET)
      sw_start && !clr_fifo |-> ##2 MEM_REQ && !MEM_WE
      && MEM_ADDR == ($past(AV_WRITEDATA, 2) & PTR_ADDR_MASK))
      else $error("first fetch address wrong");                                   // see [RULE_14]
   a_abort_idle: assert property (@(posedge REF_CLK) disable iff (RESET)
      sw_abort |=> state_ff == RXD_IDLE && !MEM_REQ) else $error("abort ignored"); // see [RULE_19]
   a_irq_gate: assert property (@(posedge REF_CLK) disable iff (RESET)
      $rose(CHAN_IRQ) |-> $past(MASTER_INT_EN) || $past(rd_int_ff))
      else $error("irq without enable");                                          // see [RULE_24]
   a_count_field: assert property (@(posedge REF_CLK) disable iff (RESET)
      rd_take && AV_ADDRESS == OFS_STATUS && $past(AV_READ && wait_ff)
      |-> AV_READDATA[ST_IRQ-1:ST_CNT_LO] == $past(total))
      else $error("status count wrong");                                          // see [RULE_02]
endmodule // rxd_dma_top

// file: rxd_dma_top_bench.sv
// self-checking bench for the receive fifo chain and dma engine
`timescale 1ns/1ps
module rxd_dma_top_bench;
   import rxd_pkg::*;
   logic        REF_CLK = 0, RESET = 1, AV_READ = 0, AV_WRITE = 0;
   logic        LOAD_VALID = 0, MASTER_INT_EN = 0;
   logic [7:0]  AV_ADDRESS = 8'h00;
   logic [31:0] AV_WRITEDATA = 32'h0, LOAD_DATA = 32'h0;
   logic [31:0] AV_READDATA, MEM_ADDR, MEM_WDATA, MEM_RDATA, q, w [4];
   logic        AV_WAITREQUEST, CHAN_IRQ, MEM_REQ, MEM_WE, MEM_ACK, MEM_ABORT;
   logic [7:0]  lv [6] = '{OFS_LOW0, OFS_HIGH0, OFS_LOW1, OFS_HIGH1, OFS_LOW2, OFS_HIGH2};
   logic [31:0] full_st;
   int          bad_count = 0, checked = 0;
   always #4 REF_CLK = ~REF_CLK;
   rxd_dma_top rxd_dma_top_i (.REF_CLK(REF_CLK), .RESET(RESET), .AV_ADDRESS(AV_ADDRESS),
      .AV_READ(AV_READ), .AV_WRITE(AV_WRITE), .AV_WRITEDATA(AV_WRITEDATA),
      .AV_READDATA(AV_READDATA), .AV_WAITREQUEST(AV_WAITREQUEST), .LOAD_VALID(LOAD_VALID),
      .LOAD_DATA(LOAD_DATA), .MASTER_INT_EN(MASTER_INT_EN), .CHAN_IRQ(CHAN_IRQ),
      .MEM_REQ(MEM_REQ), .MEM_WE(MEM_WE), .MEM_ADDR(MEM_ADDR), .MEM_WDATA(MEM_WDATA),
      .MEM_ACK(MEM_ACK), .MEM_ABORT(MEM_ABORT), .MEM_RDATA(MEM_RDATA));
   rxd_host_model rxd_host_model_i (.clk(REF_CLK), .rst(RESET), .req(MEM_REQ), .we(MEM_WE),
      .addr(MEM_ADDR), .wdata(MEM_WDATA), .ack(MEM_ACK), .abort(MEM_ABORT), .rdata(MEM_RDATA));
   task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task av(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge REF_CLK);
      AV_ADDRESS <= a;
      AV_WRITE <= wr;
      AV_READ <= !wr;
      AV_WRITEDATA <= d;
      do begin
         @(posedge REF_CLK);
      end while (AV_WAITREQUEST !== 1'b0);
      q = AV_READDATA;
      AV_WRITE <= 1'b0;
      AV_READ <= 1'b0;
   endtask
   task load(input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge REF_CLK);
         LOAD_VALID <= 1'b1;
         q = $urandom;
         LOAD_DATA <= q;
         if (i < 4) w[i] = q;
      end
      @(posedge REF_CLK);
      LOAD_VALID <= 1'b0;
      repeat (30) @(posedge REF_CLK);
   endtask
   // word aligned fields, end flag only in the last next pointer
   task desc(input logic [31:0] b, input logic [31:0] a, input logic [31:0] len, nxt);
      rxd_host_model_i.mem[b] = a;
      rxd_host_model_i.mem[b + 4] = len;
      rxd_host_model_i.mem[b + 8] = nxt;
   endtask
   task wait_st(input int b);
      int n;
      n = 0;
      do av(1'b0, OFS_STATUS, 32'h0); while (q[b] !== 1'b1 && ++n < 100);
   endtask
   function automatic logic [31:0] empty_st(input int cnt);
      return (cnt << ST_CNT_LO) | (1 << ST_E0) | (1 << ST_AE0) | (1 << ST_E1) | (1 << ST_E2)
         | (1 << ST_AE2);
   endfunction
   task end_sim;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge REF_CLK);
      bad_count++;
      end_sim;
   end
   initial begin
      void'($urandom(32'h6dd236bc));
      repeat (4) @(posedge REF_CLK);
      RESET <= 1'b0;
      av(1'b0, OFS_STATUS, 32'h0);
      chk("status", q, empty_st(0));
      for (int i = 0; i < 6; i++) begin
         av(1'b0, lv[i], 32'h0);
         chk("level", q, (i % 2) ? HIGH_RESET : LOW_RESET);
         full_st = {16'h0, 16'($urandom)};
         av(1'b1, lv[i], full_st);
         av(1'b0, lv[i], 32'h0);
         chk("level rw", q, full_st);
         av(1'b1, lv[i], (i % 2) ? HIGH_RESET : LOW_RESET);
      end
      av(1'b0, 8'h04, 32'h0);
      chk("unmapped", q, 32'h0);
      av(1'b1, OFS_STATUS, 32'hffff_ffff);
      av(1'b0, OFS_STATUS, 32'h0);
      chk("status ro", q, empty_st(0));
      $display("test registers done");
      load(3);
      av(1'b0, OFS_STATUS, 32'h0);
      chk("count", q, empty_st(3));
      for (int i = 0; i < 3; i++) begin
         av(1'b0, OFS_SWR, 32'h0);
         chk("single word", q, w[i]);
      end
      av(1'b0, OFS_STATUS, 32'h0);
      chk("count", q, empty_st(0));
      $display("test single word done");
      desc(32'h100, 32'h1000, 32'h8, 32'h122); // direction one
      desc(32'h120, 32'h2000, 32'h8, 32'h3);
      load(4);
      av(1'b1, OFS_RD_PTR, 32'h100);
      wait_st(ST_RD_INT);
      chk("dma done", q[ST_RD_INT], 1'b1);
      for (int i = 0; i < 4; i++) begin
         q = rxd_host_model_i.mem[(i < 2 ? 32'h1000 : 32'h1ff8) + 4 * i];
         chk("host word", q, w[i]);
      end
      av(1'b1, OFS_STATUS, 32'h1 << ST_RD_INT);
      av(1'b0, OFS_STATUS, 32'h0);
      chk("done clear", q, empty_st(0));
      desc(32'h140, 32'h3000, 32'h0, 32'h1);
      av(1'b1, OFS_RD_PTR, 32'h140);
      wait_st(ST_RD_ERR);
      chk("dir error", q[ST_RD_ERR], 1'b1);
      av(1'b1, OFS_STATUS, 32'h1 << ST_RD_ERR);
      av(1'b1, OFS_RD_PTR, 32'hbad0);
      wait_st(ST_RD_ERR);
      chk("bus abort", q[ST_RD_ERR], 1'b1);
      av(1'b1, OFS_STATUS, 32'h1 << ST_RD_ERR);
      desc(32'h160, 32'h4000, 32'h190, 32'h3);
      av(1'b1, OFS_RD_PTR, 32'h160);
      repeat (20) @(posedge REF_CLK);
      av(1'b0, OFS_CTRL, 32'h0);
      chk("busy", q[CT_BO_IDLE], 1'b0);
      av(1'b1, OFS_RD_PTR, 32'h0);
      av(1'b0, OFS_CTRL, 32'h0);
      chk("aborted", q[CT_BO_IDLE], 1'b1);
      $display("test dma done");
      load(12300);
      full_st = (32'h3001 << ST_CNT_LO) | 32'h0000_0e6c;
      av(1'b0, OFS_STATUS, 32'h0);
      chk("full", q, full_st);
      av(1'b1, OFS_STATUS, 32'h1 << ST_OVR);
      av(1'b0, OFS_STATUS, 32'h0);
      chk("overrun clear", q, full_st & ~(32'h1 << ST_OVR));
      $display("test fill done");
      av(1'b1, OFS_CTRL, (32'h1 << CT_CH_IEN) | (32'h1 << CT_FORCE));
      MASTER_INT_EN <= 1'b1;
      repeat (3) @(posedge REF_CLK);
      chk("irq", CHAN_IRQ, 1'b1);
      av(1'b0, OFS_STATUS, 32'h0);
      chk("active", q[ST_IRQ], 1'b1);
      MASTER_INT_EN <= 1'b0;
      repeat (3) @(posedge REF_CLK);
      chk("irq gated", CHAN_IRQ, 1'b0);
      av(1'b1, OFS_CTRL, 32'h1 << CT_FIFO_RST);
      av(1'b1, OFS_CTRL, 32'h0);
      av(1'b0, OFS_STATUS, 32'h0);
      chk("after reset", q, empty_st(0));
      $display("test irq and reset done");
      end_sim;
   end
endmodule // rxd_dma_top_bench

// file: rxd_fifo.sv
`timescale 1ns/1ps
// one fifo stage: block memory with one location kept free, registered read data
module rxd_fifo #(
   parameter int AW = 12
) (
   input  wire logic REF_CLK,
   input  wire logic RESET,
   rxd_fifo_if.mem   port
);
   logic [31:0]  mem_q [2**AW];
   logic [AW-1:0] wptr_ff;
   logic [AW-1:0] rptr_ff;
   logic [AW:0]   count_ff;
   logic [31:0]   rdata_ff;
   wire           do_wr = port.wr;
   wire           do_rd = port.rd && (count_ff != '0);

   always_ff @(posedge REF_CLK) begin
      if (do_wr) begin
         mem_q[wptr_ff] <= port.wdata;
      end
      if (do_rd) begin
         rdata_ff <= mem_q[rptr_ff];
      end
   end

   always_ff @(posedge REF_CLK) begin
      if (RESET || port.clr) begin
         wptr_ff  <= '0;
         rptr_ff  <= '0;
         count_ff <= '0;
      end else begin
         wptr_ff  <= wptr_ff + AW'(do_wr);
         rptr_ff  <= rptr_ff + AW'(do_rd);
         count_ff <= count_ff + (AW+1)'(do_wr) - (AW+1)'(do_rd);
      end
   end

   assign port.rdata = rdata_ff;
   assign port.count = count_ff;
endmodule // rxd_fifo

// file: rxd_fifo_if.sv
`timescale 1ns/1ps
// carrier between the chain controller and one fifo stage memory
interface rxd_fifo_if #(parameter int DW = 32, parameter int CW = 13);
   logic          clr;
   logic          wr;
   logic [DW-1:0] wdata;
   logic          rd;
   logic [DW-1:0] rdata;
   logic [CW-1:0] count;
   modport ctl (output clr, output wr, output wdata, output rd, input rdata, input count);
   modport mem (input clr, input wr, input wdata, input rd, output rdata, output count);
endinterface

// file: rxd_host_model.sv
// host memory model: descriptor reads and data writes
`timescale 1ns/1ps
module rxd_host_model (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        req,
   input  wire logic        we,
   input  wire logic [31:0] addr,
   input  wire logic [31:0] wdata,
   output logic             ack = 1'b0,
   output logic             abort = 1'b0,
   output logic [31:0]      rdata = 32'h0
);
   logic [31:0] mem [logic [31:0]];
   int          wait_cnt = 0;
   always @(posedge clk) begin
      ack <= 1'b0;
      abort <= 1'b0;
      rdata <= ~rdata;
      if (rst) begin
         wait_cnt <= 0;
      end else if (req && !ack && !abort) begin
         if (wait_cnt == 0) begin
            // an access to this one address ends in a target abort
            ack <= addr != 32'hbad0;
            abort <= addr == 32'hbad0;
            wait_cnt <= $urandom_range(3, 0);
            if (we) begin
               mem[addr] = wdata;
            end else begin
               rdata <= mem.exists(addr) ? mem[addr] : ~addr;
            end
         end else begin
            wait_cnt <= wait_cnt - 1;
         end
      end
   end
endmodule // rxd_host_model

// file: rxd_pkg.sv
// register map, field positions and reset values of the receive fifo chain and dma engine
package rxd_pkg;
   localparam logic [7:0]  OFS_CTRL      = 8'h78;
   localparam logic [7:0]  OFS_STATUS    = 8'h7c;
   localparam logic [7:0]  OFS_WR_PTR    = 8'h80;
   localparam logic [7:0]  OFS_RD_PTR    = 8'h84;
   localparam logic [7:0]  OFS_SWR       = 8'h88;
   localparam logic [7:0]  OFS_LOW0      = 8'h8c;
   localparam logic [7:0]  OFS_HIGH0     = 8'h90;
   localparam logic [7:0]  OFS_LOW1      = 8'h94;
   localparam logic [7:0]  OFS_HIGH1     = 8'h98;
   localparam logic [7:0]  OFS_LOW2      = 8'h9c;
   localparam logic [7:0]  OFS_HIGH2     = 8'ha0;
   // control register fields
   localparam int          CT_FIFO_RST   = 0;
   localparam int          CT_RD_IEN     = 3;
   localparam int          CT_CH_IEN     = 4;
   localparam int          CT_FORCE      = 5;
   localparam int          CT_BO_IDLE    = 18;
   localparam logic [31:0] CT_WR_MASK    = 32'h0000_0039;
   // status register fields
   localparam int          ST_IRQ        = 31;
   localparam int          ST_CNT_LO     = 16;
   localparam int          ST_CNT_W      = 15;
   localparam int          ST_RD_INT     = 15;
   localparam int          ST_WR_INT     = 14;
   localparam int          ST_RD_ERR     = 13;
   localparam int          ST_WR_ERR     = 12;
   localparam int          ST_OVR        = 11;
   localparam int          ST_E0         = 0;
   localparam int          ST_AE0        = 1;
   localparam int          ST_AF0        = 2;
   localparam int          ST_F0         = 3;
   localparam int          ST_E1         = 4;
   localparam int          ST_AF1        = 5;
   localparam int          ST_F1         = 6;
   localparam int          ST_E2         = 7;
   localparam int          ST_AE2        = 8;
   localparam int          ST_AF2        = 9;
   localparam int          ST_F2         = 10;
   // pointer word fields
   localparam int          PTR_EOC       = 0;
   localparam int          PTR_DIR       = 1;
   localparam logic [31:0] PTR_ADDR_MASK = 32'hffff_fffc;
   // level registers
   localparam int          LVL_W         = 16;
   localparam int          LVL_USED      = 12;
   localparam logic [15:0] LOW_RESET     = 16'h0010;
   localparam logic [15:0] HIGH_RESET    = 16'h0ff0;
   localparam int          N_STAGE       = 3;
   localparam logic [31:0] WORD_BYTES    = 32'h0000_0004;
endpackage
